// file: hw/rot_unit.sv
// Rotate-right execution unit: decode, operand fetch, rotate and write-back over four phases.
// Assumes the register file answers OPND_DATA combinationally-registered by the next phase.
`timescale 1ns/1ps
module rot_unit (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  // Instruction
  input  wire logic [15:0] INSTR,
  input  wire logic [3:0]  BANK_SELECT_POINTER,
  input  wire logic        CARRY_IN,
  // Operand read port
  output logic [11:0]      OPND_ADDR,
  output logic             OPND_RD,
  input  wire logic [7:0]  OPND_DATA,
  // Result write port
  output logic [11:0]      WR_ADDR,
  output logic [7:0]       WR_DATA,
  output logic             WR_FILE,
  output logic             WR_WORKING_ACCUMULATOR,
  // Flags
  output logic             FLAG_C,
  output logic             FLAG_N,
  output logic             FLAG_Z,
  output logic             FLAG_C_WE,
  output logic             FLAG_NZ_WE,
  output logic             BUSY
);
  import rot_pkg::*;

  typedef struct packed {
    phase_t      ph;
    logic        valid;
    logic        thru;
    logic        dest;
    logic [11:0] addr;
    logic [7:0]  opnd;
    logic [7:0]  res;
    logic        c;
    logic        n;
    logic        z;
    logic        rd;
    logic        wr_f;
    logic        wr_w;
    logic        c_we;
    logic        nz_we;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [7:0] k_res;
  logic       k_c;
  logic       k_n;
  logic       k_z;

  rot_compute u_kernel (
    .operand      (s_q.opnd),
    .carry_in     (CARRY_IN),
    .through_carry(s_q.thru),
    .result       (k_res),
    .carry_out    (k_c),
    .negative     (k_n),
    .zero         (k_z)
  );

  always_comb begin
    s_d       = s_q;
    s_d.rd    = 1'b0;
    s_d.wr_f  = 1'b0;
    s_d.wr_w  = 1'b0;
    s_d.c_we  = 1'b0;
    s_d.nz_we = 1'b0;
    case (s_q.ph)
      PH_Q1: begin
        s_d.ph    = PH_Q2; // RULE10
        s_d.valid = (INSTR[OPC_HI:OPC_LO] == OPC_RR_CIRCULAR) || // RULE8
                    (INSTR[OPC_HI:OPC_LO] == OPC_RR_CARRY);      // RULE9
        s_d.thru  = (INSTR[OPC_HI:OPC_LO] == OPC_RR_CARRY);      // RULE9
        s_d.dest  = INSTR[DEST_BIT];
        if (INSTR[BANK_BIT]) begin
          s_d.addr = {BANK_SELECT_POINTER, INSTR[7:0]}; // RULE5
        end else if (INSTR[7:0] < ACCESS_SPLIT) begin
          s_d.addr = {ACCESS_BANK, INSTR[7:0]}; // RULE4
        end else begin
          s_d.addr = {ACCESS_HI_BANK, INSTR[7:0]}; // RULE4
        end
        s_d.rd = s_d.valid;
      end
      PH_Q2: begin
        s_d.ph   = PH_Q3; // RULE10
        s_d.opnd = OPND_DATA;
      end
      PH_Q3: begin
        s_d.ph  = PH_Q4; // RULE10
        s_d.res = k_res;
        s_d.c   = k_c;
        s_d.n   = k_n;
        s_d.z   = k_z;
        s_d.wr_f  = s_q.valid && s_q.dest;  // RULE3
        s_d.wr_w  = s_q.valid && !s_q.dest; // RULE2
        s_d.c_we  = s_q.valid && s_q.thru;  // RULE1 RULE6
        s_d.nz_we = s_q.valid;              // RULE7
      end
      PH_Q4: begin
        s_d.ph    = PH_Q1; // RULE10
        s_d.valid = 1'b0;
      end
      default: begin
        s_d.ph    = PH_Q1;
        s_d.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s_q <= '{ph: PH_Q1, addr: ZERO12, opnd: ZERO8, res: ZERO8, default: 1'b0};
    end else if (CLK_EN) begin
      s_q <= s_d;
    end
  end

  // Write strobes pulse in Q4 only; WR_FILE is gated by the destination bit, so the file register is untouched on accumulator writes
  assign OPND_ADDR              = s_q.addr;
  assign OPND_RD                = s_q.rd;
  assign WR_ADDR                = s_q.addr;
  assign WR_DATA                = s_q.res;
  assign WR_FILE                = s_q.wr_f;
  assign WR_WORKING_ACCUMULATOR = s_q.wr_w;
  assign FLAG_C                 = s_q.c;
  assign FLAG_N                 = s_q.n;
  assign FLAG_Z                 = s_q.z;
  assign FLAG_C_WE              = s_q.c_we;
  assign FLAG_NZ_WE             = s_q.nz_we;
  assign BUSY                   = s_q.valid;
endmodule // rot_unit

// file: hw/rot_pkg.sv
// Package: opcode fields, phase encoding and access-bank address constants of the rotate-right unit.
// Assumes a core that presents one 16-bit instruction word per instruction cycle.
// Function
// RULE1: Through-carry rotate: shift right, bit 0 to carry, old carry to bit 7, update C/N/Z.
// RULE2: Destination bit 0 writes result to working accumulator; file register untouched.
// RULE3: Destination bit 1, the default, writes result back to addressed file register.
// RULE4: Bank bit 0 resolves the operand address in the access bank, ignoring bank pointer.
// RULE5: Bank bit 1 resolves the operand address in the bank given by bank pointer.
// RULE6: Circular rotate: each bit moves one lower, bit 0 copied to bit 7, carry kept.
// RULE7: Circular rotate updates only negative and zero flags from the result.
// RULE8: Circular rotate opcode is 0100 00 then destination, bank and 8-bit address.
// RULE9: Through-carry rotate opcode is 0011 00 then destination, bank and 8-bit address.
// RULE10: One word, one cycle: decode Q1, read Q2, process Q3, write Q4.
package rot_pkg;
  localparam logic [5:0] OPC_RR_CARRY    = 6'h0C;
  localparam logic [5:0] OPC_RR_CIRCULAR = 6'h10;
  localparam int         OPC_HI          = 15;
  localparam int         OPC_LO          = 10;
  localparam int         DEST_BIT        = 9;
  localparam int         BANK_BIT        = 8;
  localparam int         MSB             = 7;
  localparam logic [3:0] ACCESS_BANK     = 4'h0;
  localparam logic [7:0] ACCESS_SPLIT    = 8'h80;
  localparam logic [3:0] ACCESS_HI_BANK  = 4'hF;
  localparam logic [7:0] ZERO8           = 8'h00;
  localparam logic [11:0] ZERO12         = 12'h000;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } phase_t;
endpackage

// file: hw/rot_compute.sv
// Combinational rotate kernel: result and carry/negative/zero for both rotate kinds.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
module rot_compute (
  // Operand
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  input  wire logic       through_carry,
  // Result
  output logic [7:0]      result,
  output logic            carry_out,
  output logic            negative,
  output logic            zero
);
  import rot_pkg::*;
  always_comb begin
    if (through_carry) begin
      result    = {carry_in, operand[MSB:1]}; // RULE1
      carry_out = operand[0];                 // RULE1
    end else begin
      result    = {operand[0], operand[MSB:1]}; // RULE6
      carry_out = carry_in;                     // RULE6
    end
    negative = result[MSB]; // RULE7
    zero     = (result == ZERO8); // RULE7
  end
endmodule // rot_compute

// file: tb/rot_unit_monitor.sv
// Port checker for the rotate unit.
// Assumes CLK_EN is held high.
`timescale 1ns/1ps
module rot_unit_monitor (
  input wire logic        REF_CLK, SYS_RST, CARRY_IN, OPND_RD, WR_FILE, WR_WORKING_ACCUMULATOR,
  input wire logic        FLAG_C, FLAG_N, FLAG_Z, FLAG_C_WE, FLAG_NZ_WE, BUSY,
  input wire logic [7:0]  OPND_DATA, WR_DATA,
  input wire logic [11:0] OPND_ADDR, WR_ADDR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  rd_pulse_a: assert property (OPND_RD |=> !OPND_RD) else $error("read long");
  rd_write_a: assert property (OPND_RD |-> ##2 (WR_FILE || WR_WORKING_ACCUMULATOR)) else $error("no write");
  busy_span_a: assert property (OPND_RD |-> BUSY ##1 BUSY ##1 BUSY) else $error("busy drop");
  one_dest_a: assert property (!(WR_FILE && WR_WORKING_ACCUMULATOR)) else $error("two dest");
  same_addr_a: assert property (WR_FILE |-> WR_ADDR == $past(OPND_ADDR, 2)) else $error("addr moved");
  nz_flags_a: assert property (FLAG_NZ_WE |-> FLAG_N == WR_DATA[7] && FLAG_Z == (WR_DATA == 8'h00))
    else $error("bad N Z");
  carry_rot_a: assert property (FLAG_C_WE |-> WR_DATA == {$past(CARRY_IN), $past(OPND_DATA[7:1], 2)}
    && FLAG_C == $past(OPND_DATA[0], 2)) else $error("bad carry rotate");
  circ_rot_a: assert property (FLAG_NZ_WE && !FLAG_C_WE |->
    WR_DATA == {$past(OPND_DATA[0], 2), $past(OPND_DATA[7:1], 2)}) else $error("bad rotate");
  cover property (WR_FILE);
  cover property (WR_WORKING_ACCUMULATOR);
  cover property (FLAG_C_WE);
endmodule // rot_unit_monitor
bind rot_unit rot_unit_monitor mon (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CARRY_IN(CARRY_IN), .OPND_RD(OPND_RD),
  .WR_FILE(WR_FILE), .WR_WORKING_ACCUMULATOR(WR_WORKING_ACCUMULATOR), .FLAG_C(FLAG_C), .FLAG_N(FLAG_N),
  .FLAG_Z(FLAG_Z), .FLAG_C_WE(FLAG_C_WE), .FLAG_NZ_WE(FLAG_NZ_WE), .BUSY(BUSY), .OPND_DATA(OPND_DATA),
  .WR_DATA(WR_DATA), .OPND_ADDR(OPND_ADDR), .WR_ADDR(WR_ADDR));

// file: tb/rot_unit_tb.sv
// Self-checking bench for the rotate unit.
// Assumes the unit alone, one instruction each four cycles.
`timescale 1ns/1ps
module rot_unit_tb;
  import rot_pkg::*;
  logic        clk = 0, rst = 1, cin = 0, en = 1, rd, wf, wa, fc, fn, fz, cwe, nzwe, busy;
  logic [15:0] instr = 16'h0000;
  logic [3:0]  bsp = 4'h0;
  logic [7:0]  opd = 8'h00, wd;
  logic [11:0] oa, wadr;
  int          fails = 0, n_tests = 0;
  initial forever #20 clk = ~clk;
  rot_unit dut (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(en), .INSTR(instr), .BANK_SELECT_POINTER(bsp),
    .CARRY_IN(cin), .OPND_ADDR(oa), .OPND_RD(rd), .OPND_DATA(opd), .WR_ADDR(wadr), .WR_DATA(wd), .WR_FILE(wf),
    .WR_WORKING_ACCUMULATOR(wa), .FLAG_C(fc), .FLAG_N(fn), .FLAG_Z(fz), .FLAG_C_WE(cwe), .FLAG_NZ_WE(nzwe),
    .BUSY(busy));
  task chk(string nm, logic [11:0] s, logic [11:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task print_verdict;
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Entered at the edge before decode; returns at the next decode boundary
  task op(logic [15:0] i, logic [3:0] b, logic [7:0] d, logic c);
    logic       rot, cy;
    logic [7:0] r;
    cy = i[15:10] == OPC_RR_CARRY;
    rot = cy || i[15:10] == OPC_RR_CIRCULAR;
    r = {cy ? c : d[0], d[7:1]};
    instr <= i;
    bsp <= b;
    @(posedge clk);
    opd <= d;
    cin <= c;
    #1 chk("read", rd, rot);
    repeat (2) @(posedge clk);
    #1 chk("busy", busy, rot);
    chk("file", wf, rot & i[9]);
    chk("acc", wa, rot & ~i[9]);
    chk("cwe", cwe, cy);
    if (rot) begin
      chk("addr", oa, {i[8] ? b : {4{i[7]}}, i[7:0]});
      chk("result", wd, r);
      chk("flags", {fc, fn, fz}, {cy ? d[0] : c, r[7], r == 8'h00});
    end
    @(posedge clk);
  endtask
  task t_carry;
    op(16'h3012, 4'h5, 8'hE6, 1'b0);
    op(16'h3334, 4'hA, 8'h01, 1'b1);
  endtask
  task t_circ;
    op(16'h4285, 4'h5, 8'hD7, 1'b1);
    op(16'h41FF, 4'hF, 8'h00, 1'b0);
  endtask
  // Neighbouring opcodes must not be taken for rotates
  task t_refused;
    op(16'h3412, 4'h1, 8'h81, 1'b1);
    op(16'h4400, 4'h1, 8'h81, 1'b1);
  endtask
  // Enable low must freeze the phase counter, so a waiting rotate is not decoded
  task t_stall;
    en <= 1'b0;
    instr <= 16'h3012;
    repeat (3) @(posedge clk);
    #1 chk("frozen rd", rd, 1'b0);
    chk("frozen busy", busy, 1'b0);
    @(posedge clk);
    en <= 1'b1;
    op(16'h3012, 4'h5, 8'hE6, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_carry;
    t_circ;
    t_refused;
    t_stall;
    print_verdict;
  end
  initial begin
    repeat (200) @(posedge clk);
    fails++;
    print_verdict;
  end
endmodule // rot_unit_tb
